// ===== logic/ncosc_top.v
`include "ncosc_regs.vh"

module ncosc_top #(
   parameter AW = 12,
   parameter NOSC = 4
) (
   aclk,
   aresetn,
   aclken,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_awaddr,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_bresp,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_araddr,
   s_axi_rvalid,
   s_axi_rready,
   s_axi_rdata,
   s_axi_rresp,
   sysref,
   fast_reconfig_chip_select,
   fast_reconfig_select,
   fast_accumulator_reset_mask,
   datapath_enable,
   sample_valid,
   sample_lsb,
   mixer_enable,
   synth_mode_enable,
   synth_config,
   self_coherent_select,
   fast_reconfig_enable,
   phase_continuous_mask,
   use_ref_zero,
   reseed_on_change,
   sync_event,
   acc_reset,
   apply_spi_changes,
   apply_fast_changes,
   lsb_out
);
   input wire aclk;
   input wire aresetn;
   input wire aclken;
   input wire s_axi_awvalid;
   output wire s_axi_awready;
   input wire [AW-1:0] s_axi_awaddr;
   input wire s_axi_wvalid;
   output wire s_axi_wready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   output wire s_axi_bvalid;
   input wire s_axi_bready;
   output wire [1:0] s_axi_bresp;
   input wire s_axi_arvalid;
   output wire s_axi_arready;
   input wire [AW-1:0] s_axi_araddr;
   output wire s_axi_rvalid;
   input wire s_axi_rready;
   output wire [31:0] s_axi_rdata;
   output wire [1:0] s_axi_rresp;
   input wire sysref;
   input wire fast_reconfig_chip_select;
   input wire fast_reconfig_select;
   input wire [NOSC-1:0] fast_accumulator_reset_mask;
   input wire datapath_enable;
   input wire sample_valid;
   input wire sample_lsb;
   output wire mixer_enable;
   output wire synth_mode_enable;
   output wire synth_config;
   output wire self_coherent_select;
   output wire fast_reconfig_enable;
   output wire [NOSC-1:0] phase_continuous_mask;
   output wire [NOSC-1:0] use_ref_zero;
   output wire [NOSC-1:0] reseed_on_change;
   output wire sync_event;
   output wire [NOSC-1:0] acc_reset;
   output wire apply_spi_changes;
   output wire apply_fast_changes;
   output wire lsb_out;

   // -----------------------------------------
   // Register decode
   // -----------------------------------------
   // Index decode, used by both read and write paths
   function [2:0] ncosc_dec;
      input [AW-1:0] a;
      begin
         ncosc_dec = 3'h7;
         if (a[1:0] == 2'h0) begin
            case (a[AW-1:2])
               `NCOSC_IDX_CTRL: ncosc_dec = 3'h0;
               `NCOSC_IDX_CONT: ncosc_dec = 3'h1;
               `NCOSC_IDX_SYNC: ncosc_dec = 3'h2;
               `NCOSC_IDX_AR: ncosc_dec = 3'h3;
               `NCOSC_IDX_TRIG: ncosc_dec = 3'h4;
               default: ncosc_dec = 3'h7;
            endcase
         end
      end
   endfunction

   reg [7:0] ctrl_r;
   reg [NOSC-1:0] cont_r;
   reg [1:0] src_r;
   reg [NOSC-1:0] ar_r;
   reg trig_r;

   reg aw_have_r;
   reg [AW-1:0] aw_addr_r;
   reg w_have_r;
   reg [7:0] w_data_r;
   reg w_lane_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0] rresp_r;

   // -----------------------------------------
   // AXI4-Lite handshakes
   // -----------------------------------------
   // Readies drop with the clock enable so no item is taken while frozen
   assign s_axi_awready = aclken & ~aw_have_r & ~bvalid_r;
   assign s_axi_wready = aclken & ~w_have_r & ~bvalid_r;
   assign s_axi_arready = aclken & ~rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   wire do_wr = aw_have_r & w_have_r & ~bvalid_r;
   wire [2:0] wsel = ncosc_dec(aw_addr_r);
   wire wr_lane = do_wr & w_lane_r;
   wire [2:0] rsel = ncosc_dec(s_axi_araddr);
   wire trig_rise = wr_lane & (wsel == 3'h4) & w_data_r[0] & ~trig_r; // RULE20

   // Write address and data are caught in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= {AW{1'b0}};
         w_have_r <= 1'b0;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `NCOSC_RESP_OK;
      end else if (aclken) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (wsel == 3'h7) ? `NCOSC_RESP_ERR : `NCOSC_RESP_OK;
         end else if (bvalid_r & s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Register storage, only byte lane zero carries data
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `NCOSC_RST_CTRL;
         cont_r <= `NCOSC_RST_CONT;
         src_r <= `NCOSC_RST_SRC;
         ar_r <= `NCOSC_RST_AR;
         trig_r <= 1'b0;
      end else if (aclken && wr_lane) begin
         case (wsel)
            3'h0: begin
               ctrl_r[`NCOSC_B_MIX] <= w_data_r[`NCOSC_B_MIX];
               ctrl_r[`NCOSC_B_DDS] <= w_data_r[`NCOSC_B_DDS];
               ctrl_r[`NCOSC_B_SC] <= w_data_r[`NCOSC_B_SC];
               ctrl_r[`NCOSC_B_FR] <= w_data_r[`NCOSC_B_FR];
            end
            3'h1: cont_r <= w_data_r[NOSC-1:0];
            3'h2: src_r <= w_data_r[1:0];
            3'h3: ar_r <= w_data_r[NOSC-1:0];
            3'h4: trig_r <= w_data_r[0]; // RULE20
            default: trig_r <= trig_r;
         endcase
      end
   end

   // Read path; reserved bits come back as zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `NCOSC_RESP_OK;
      end else if (aclken) begin
         if (s_axi_arvalid & s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= (rsel == 3'h7) ? `NCOSC_RESP_ERR : `NCOSC_RESP_OK;
            case (rsel)
               3'h0: rdata_r <= {24'h000000, ctrl_r};
               3'h1: rdata_r <= {{(32-NOSC){1'b0}}, cont_r};
               3'h2: rdata_r <= {30'h00000000, src_r};
               3'h3: rdata_r <= {{(32-NOSC){1'b0}}, ar_r};
               3'h4: rdata_r <= {31'h00000000, trig_r}; // RULE20
               default: rdata_r <= 32'h00000000;
            endcase
         end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------
   // Pin synchronisers
   // -----------------------------------------
   reg [1:0] sref_s_r;
   reg [1:0] cs_s_r;
   reg sref_d_r;
   reg cs_d_r;

   // Edge detect sits after the second stage only
   always @(posedge aclk) begin
      if (!aresetn) begin
         sref_s_r <= 2'b00;
         cs_s_r <= 2'b11;
         sref_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else if (aclken) begin
         sref_s_r <= {sref_s_r[0], sysref};
         cs_s_r <= {cs_s_r[0], fast_reconfig_chip_select};
         sref_d_r <= sref_s_r[1];
         cs_d_r <= cs_s_r[1];
      end
   end

   wire sref_rise = sref_s_r[1] & ~sref_d_r;
   wire cs_rise = cs_s_r[1] & ~cs_d_r;

   // -----------------------------------------
   // Static oscillator controls
   // -----------------------------------------
   wire fr_on = ctrl_r[`NCOSC_B_FR];
   assign fast_reconfig_enable = fr_on; // RULE1
   assign mixer_enable = ctrl_r[`NCOSC_B_MIX]; // RULE5
   assign synth_mode_enable = ctrl_r[`NCOSC_B_DDS];
   assign self_coherent_select = ctrl_r[`NCOSC_B_SC];
   assign phase_continuous_mask = cont_r;

   genvar gi;
   generate
      for (gi = 0; gi < NOSC; gi = gi + 1) begin : g_osc
         // Coherent oscillators only follow the channel-zero counter
         assign use_ref_zero[gi] = ctrl_r[`NCOSC_B_SC] & ~cont_r[gi]; // RULE2 RULE3
         assign reseed_on_change[gi] = ~cont_r[gi]; // RULE6 RULE7
      end
   endgenerate

   reg dp_d_r;
   reg synth_cfg_r;
   assign synth_config = synth_cfg_r;

   // Synthesis setup is captured only as the datapath turns on
   always @(posedge aclk) begin
      if (!aresetn) begin
         dp_d_r <= 1'b0;
         synth_cfg_r <= 1'b0;
      end else if (aclken) begin
         dp_d_r <= datapath_enable;
         if (datapath_enable & ~dp_d_r) begin
            synth_cfg_r <= ctrl_r[`NCOSC_B_DDS]; // RULE4
         end else if (!datapath_enable) begin
            synth_cfg_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------
   // Trigger selection
   // -----------------------------------------
   reg once_armed_r;
   reg fr_armed_r;
   reg [2:0] low_cnt_r;
   reg [2:0] high_cnt_r;
   wire fr_sel_edge = fr_on & fast_reconfig_select & cs_rise;
   wire spi_lsb = ~fr_on & trig_r & (src_r == `NCOSC_SRC_LSB); // RULE13
   wire pat_en = spi_lsb | fr_armed_r;
   wire high_ok = (low_cnt_r >= `NCOSC_RUN);
   wire pat_hit = pat_en & sample_valid & sample_lsb & high_ok &
      (high_cnt_r == (`NCOSC_RUN - 3'h1));

   reg fire;
   // One fire term per source, all events share it
   always @* begin
      fire = 1'b0;
      if (!fr_on) begin // RULE9
         case (src_r)
            `NCOSC_SRC_NOW: fire = trig_rise; // RULE10
            `NCOSC_SRC_ONCE: fire = once_armed_r & sref_rise; // RULE11
            `NCOSC_SRC_EVERY: fire = trig_r & sref_rise; // RULE12
            `NCOSC_SRC_LSB: fire = pat_hit; // RULE13
            default: fire = 1'b0;
         endcase
      end else begin
         case (src_r)
            `NCOSC_SRC_NOW: fire = fr_sel_edge; // RULE15
            `NCOSC_SRC_LSB: fire = pat_hit; // RULE16
            default: fire = 1'b0;
         endcase
      end
   end

   // Arming state; a new arm beats a same-cycle fire
   always @(posedge aclk) begin
      if (!aresetn) begin
         once_armed_r <= 1'b0;
         fr_armed_r <= 1'b0;
      end else if (aclken) begin
         if (fr_on | (src_r != `NCOSC_SRC_ONCE)) begin
            once_armed_r <= 1'b0;
         end else if (trig_rise) begin
            once_armed_r <= 1'b1; // RULE11
         end else if (sref_rise) begin
            once_armed_r <= 1'b0;
         end
         if (!fr_on | (src_r != `NCOSC_SRC_LSB)) begin
            fr_armed_r <= 1'b0;
         end else if (fr_sel_edge) begin
            fr_armed_r <= 1'b1; // RULE16
         end else if (pat_hit) begin
            fr_armed_r <= 1'b0; // RULE18
         end
      end
   end

   // -----------------------------------------
   // LSB pattern detector
   // -----------------------------------------
   // Low run saturates so a long low stretch still counts as four
   always @(posedge aclk) begin
      if (!aresetn) begin
         low_cnt_r <= 3'h0;
         high_cnt_r <= 3'h0;
      end else if (aclken) begin
         if (!pat_en) begin
            low_cnt_r <= 3'h0;
            high_cnt_r <= 3'h0;
         end else if (sample_valid) begin
            if (!sample_lsb) begin
               high_cnt_r <= 3'h0;
               if (!high_ok) begin
                  low_cnt_r <= low_cnt_r + 3'h1;
               end else if (high_cnt_r != 3'h0) begin
                  low_cnt_r <= 3'h1;
               end
            end else if (pat_hit) begin
               low_cnt_r <= 3'h0; // RULE22
               high_cnt_r <= 3'h0;
            end else if (high_ok) begin
               high_cnt_r <= high_cnt_r + 3'h1;
            end else begin
               low_cnt_r <= 3'h0;
            end
         end
      end
   end

   // LSB forced low only while the fast path waits
   // Gated by the enable too, so dropping fast mode frees the bit at once
   assign lsb_out = sample_lsb & ~(fr_armed_r & fr_on); // RULE17 RULE18

   // -----------------------------------------
   // Event outputs
   // -----------------------------------------
   reg ev_r;
   reg [NOSC-1:0] acc_r;
   reg spi_ap_r;
   reg fast_ap_r;
   wire [NOSC-1:0] mask_sel = fr_on ? fast_accumulator_reset_mask : ar_r; // RULE14

   // Registered so every event lands in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         ev_r <= 1'b0;
         acc_r <= {NOSC{1'b0}};
         spi_ap_r <= 1'b0;
         fast_ap_r <= 1'b0;
      end else if (aclken) begin
         ev_r <= fire;
         acc_r <= fire ? mask_sel : {NOSC{1'b0}}; // RULE21
         spi_ap_r <= fire & ~fr_on; // RULE9
         fast_ap_r <= fire & fr_on; // RULE14
      end
   end

   assign sync_event = ev_r;
   assign acc_reset = acc_r;
   assign apply_spi_changes = spi_ap_r;
   assign apply_fast_changes = fast_ap_r;
endmodule

// ===== shared/ncosc_regs.vh
// Overview of operation
// RULE1 - Fast-reconfig enable hands oscillator control to the fast-reconfig registers.
// RULE2 - Self-coherent select makes oscillators use channel-zero reference counter.
// RULE3 - Self-coherent select affects only oscillators in phase-coherent mode.
// RULE4 - Synth mode configures all up-converters for synthesis when datapath enables.
// RULE5 - Mixer enable multiplies up-converter samples by oscillator output.
// RULE6 - Set continuous bit: frequency changes do not reseed that accumulator.
// RULE7 - Clear continuous bit: frequency changes reseed accumulator from main counter.
// RULE8 - Host writes the continuous mask only while datapath is disabled.
// RULE9 - Without fast reconfig, source field selects what triggers sync events.
// RULE10 - Source 0: setting trigger bit fires all selected events at once.
// RULE11 - Source 1: setting trigger bit arms one event at next SYSREF rise.
// RULE12 - Source 2: events fire every SYSREF rise while trigger bit high.
// RULE13 - Source 3: fire on fourth high LSB after at least four lows.
// RULE14 - In fast reconfig, trigger governs fast reset mask and fast changes.
// RULE15 - Fast source 0 with select: fire at chip-select rising edge.
// RULE16 - Fast source 3 with select: chip-select rise arms LSB pattern trigger.
// RULE17 - While armed for the pattern, sample LSB is replaced by zero.
// RULE18 - After the fourth high sample, LSB is ordinary data again.
// RULE19 - Host changes source only with trigger bit zero and chip select high.
// RULE20 - Writing one over zero to trigger bit fires; reads return written value.
// RULE21 - Each set accumulator reset mask bit resets that accumulator per event.
// RULE22 - After a pattern fire, a fresh run of four lows is required.
`ifndef NCOSC_REGS_VH
`define NCOSC_REGS_VH
// Register indexes, byte address is four times these
`define NCOSC_IDX_CTRL 10'h300
`define NCOSC_IDX_CONT 10'h301
`define NCOSC_IDX_SYNC 10'h302
`define NCOSC_IDX_AR 10'h303
`define NCOSC_IDX_TRIG 10'h304
// Control fields
`define NCOSC_B_MIX 0
`define NCOSC_B_DDS 1
`define NCOSC_B_SC 2
`define NCOSC_B_FR 7
`define NCOSC_RST_CTRL 8'h00
`define NCOSC_RST_CONT 4'h0
`define NCOSC_RST_SRC 2'h0
`define NCOSC_RST_AR 4'hF
// Trigger sources
`define NCOSC_SRC_NOW 2'h0
`define NCOSC_SRC_ONCE 2'h1
`define NCOSC_SRC_EVERY 2'h2
`define NCOSC_SRC_LSB 2'h3
// Pattern run length
`define NCOSC_RUN 3'h4
`define NCOSC_RESP_OK 2'h0
`define NCOSC_RESP_ERR 2'h2
`endif

// ===== verif/ncosc_sva.sv
module ncosc_sva (
   input wire aclk,
   input wire aresetn,
   input wire aclken,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire datapath_enable,
   input wire synth_mode_enable,
   input wire synth_config,
   input wire self_coherent_select,
   input wire fast_reconfig_enable,
   input wire [3:0] phase_continuous_mask,
   input wire [3:0] use_ref_zero,
   input wire [3:0] reseed_on_change,
   input wire [3:0] fast_accumulator_reset_mask,
   input wire sync_event,
   input wire [3:0] acc_reset,
   input wire apply_spi_changes,
   input wire apply_fast_changes,
   input wire sample_lsb,
   input wire lsb_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Frozen cycles carry no meaning, so they are skipped like reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !aclken);
   // ------
   // Steps
   // ------
   sequence dp_rise;
      !datapath_enable ##1 datapath_enable;
   endsequence
   sequence one_pulse;
      sync_event ##1 !sync_event;
   endsequence
   ref_zero_a: assert property (use_ref_zero == ({4{self_coherent_select}} & ~phase_continuous_mask))
      else $error("reference choice wrong");
   reseed_map_a: assert property (reseed_on_change == ~phase_continuous_mask)
      else $error("reseed choice wrong");
   pulse_once_a: assert property (sync_event |-> one_pulse)
      else $error("event pulse too long");
   event_only_a: assert property (apply_spi_changes || apply_fast_changes || acc_reset != 4'h0 |-> sync_event)
      else $error("event output without event");
   apply_path_a: assert property (sync_event |-> apply_fast_changes == $past(fast_reconfig_enable)
      && apply_spi_changes == !$past(fast_reconfig_enable))
      else $error("wrong change path");
   fast_mask_a: assert property (sync_event && $past(fast_reconfig_enable)
      |-> acc_reset == $past(fast_accumulator_reset_mask))
      else $error("fast reset mask wrong");
   lsb_pass_a: assert property (!fast_reconfig_enable |-> lsb_out == sample_lsb)
      else $error("lsb altered");
   lsb_data_a: assert property (sync_event && fast_reconfig_enable |-> lsb_out == sample_lsb)
      else $error("lsb still zeroed");
   synth_take_a: assert property (dp_rise |=> synth_config == $past(synth_mode_enable))
      else $error("synth not taken");
   synth_idle_a: assert property (!datapath_enable |=> !synth_config)
      else $error("synth set while idle");
   rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
endmodule

bind ncosc_top ncosc_sva chk (.*);

// ===== verif/ncosc_far.sv
module ncosc_far (
   input wire logic aclk,
   output logic sysref,
   output logic fast_reconfig_chip_select,
   output logic fast_reconfig_select,
   output logic [3:0] fast_accumulator_reset_mask,
   output logic sample_valid,
   output logic sample_lsb
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy;
   // Quiet levels; chip select idles high
   initial begin
      sysref = 1'b0;
      fast_reconfig_chip_select = 1'b1;
      fast_reconfig_select = 1'b0;
      fast_accumulator_reset_mask = 4'h0;
      sample_valid = 1'b1;
      sample_lsb = 1'b0;
      busy = 1'b0;
   end
   // Idle stream alternates, so it never forms a trigger pattern
   always @(posedge aclk) if (!busy) sample_lsb <= ~sample_lsb;
   task pulse_sysref;
      @(posedge aclk);
      sysref <= 1'b1;
      repeat (4) @(posedge aclk);
      sysref <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
   task pulse_cs(input logic sel, input logic [3:0] m);
      @(posedge aclk);
      fast_reconfig_select <= sel;
      fast_accumulator_reset_mask <= m;
      fast_reconfig_chip_select <= 1'b0;
      repeat (4) @(posedge aclk);
      fast_reconfig_chip_select <= 1'b1;
      repeat (6) @(posedge aclk);
      fast_reconfig_select <= 1'b0;
   endtask
   // Framed by one high and one low, so the low run is exact
   task lsb_run(input int lo, input int hi);
      busy <= 1'b1;
      @(posedge aclk);
      sample_lsb <= 1'b1;
      repeat (lo) @(posedge aclk) sample_lsb <= 1'b0;
      repeat (hi) @(posedge aclk) sample_lsb <= 1'b1;
      @(posedge aclk);
      sample_lsb <= 1'b0;
      busy <= 1'b0;
   endtask
endmodule

// ===== verif/tb_oscillator_sync_config_control.sv
`include "ncosc_regs.vh"

module tb_oscillator_sync_config_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, aclken, datapath_enable, sysref, sample_valid, sample_lsb, lsb_out;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb, fast_accumulator_reset_mask, phase_continuous_mask, use_ref_zero;
   logic [3:0] reseed_on_change, acc_reset, last_ar;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
   logic fast_reconfig_chip_select, fast_reconfig_select, mixer_enable, synth_mode_enable, synth_config;
   logic self_coherent_select, fast_reconfig_enable, sync_event, apply_spi_changes, apply_fast_changes, last_fast;
   logic [7:0] d;
   logic [7:0] w [5];
   int n_errors = 0;
   int num_checks = 0;
   int n_ev = 0;
   int n_zero = 0;
   int b, z;
   wire [3:0] ctl = {fast_reconfig_enable, self_coherent_select, synth_mode_enable, mixer_enable};

   ncosc_top dut (.*);
   ncosc_far far (.*);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // Counted mid-cycle, once registered pulses have settled
   always @(negedge aclk) begin
      if (sync_event === 1'b1) begin
         n_ev++;
         last_ar = acc_reset;
         last_fast = apply_fast_changes;
      end
      if (sample_lsb === 1'b1 && lsb_out === 1'b0) n_zero++;
   end

   function automatic logic [31:0] rmask(input int i);
      case (i)
         0: return 32'h00000087;
         1, 3: return 32'h0000000F;
         2: return 32'h00000003;
         4: return 32'h00000001;
         default: return 32'h00000000;
      endcase
   endfunction

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task end_sim;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   // Events seen since the previous count
   task evs(input string nm, input int n);
      cyc(8);
      chk(nm, n_ev - b, n);
      b = n_ev;
   endtask

   // Ready is looked at mid-cycle; it cannot change before the edge
   task wr(input logic [9:0] i, input logic [7:0] v);
      logic a, c;
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      @(negedge aclk);
      while (s_axi_awvalid || s_axi_wvalid) begin
         a = s_axi_awready;
         c = s_axi_wready;
         @(posedge aclk);
         if (a) s_axi_awvalid <= 1'b0;
         if (c) s_axi_wvalid <= 1'b0;
         @(negedge aclk);
      end
      while (s_axi_bvalid !== 1'b1) @(negedge aclk);
      br = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task rd(input logic [9:0] i);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      @(negedge aclk);
      while (s_axi_arready !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(negedge aclk);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   initial begin
      void'($urandom(32'hE1C71114));
      aresetn = 1'b0;
      aclken = 1'b1;
      datapath_enable = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset table, then one unmapped word
      for (int i = 0; i < 6; i++) begin
         rd(10'(`NCOSC_IDX_CTRL + i));
         chk("reset", rv, i == 3 ? 32'h0000000F : 32'h00000000);
         chk("resp", rr, i < 5 ? `NCOSC_RESP_OK : `NCOSC_RESP_ERR);
      end
      // Unmapped word refuses the write
      wr(10'(`NCOSC_IDX_TRIG + 1), 8'h01);
      chk("wresp", br, `NCOSC_RESP_ERR);
      for (int k = 0; k < 6; k++) begin
         wr(`NCOSC_IDX_TRIG, 8'h00);
         for (int i = 0; i < 5; i++) begin
            w[i] = 8'($urandom);
            wr(10'(`NCOSC_IDX_CTRL + i), w[i]);
            rd(10'(`NCOSC_IDX_CTRL + i));
            chk("readback", rv, {24'h000000, w[i]} & rmask(i));
         end
         chk("ctrl", ctl, {w[0][7], w[0][2:0]});
         chk("cont", phase_continuous_mask, w[1][3:0]);
      end
      wr(`NCOSC_IDX_TRIG, 8'h00);
      wr(`NCOSC_IDX_CTRL, 8'h00);
      wr(`NCOSC_IDX_SYNC, {6'h00, `NCOSC_SRC_NOW});
      d = {4'h0, 4'($urandom_range(15, 1))};
      wr(`NCOSC_IDX_AR, d);
      chk("wresp ok", br, `NCOSC_RESP_OK);
      // Lane zero strobe low leaves the mask untouched
      s_axi_wstrb <= 4'hE;
      wr(`NCOSC_IDX_AR, 8'h00);
      s_axi_wstrb <= 4'hF;
      rd(`NCOSC_IDX_AR);
      chk("strobe", rv, {28'h0000000, d[3:0]});
      b = n_ev;
      wr(`NCOSC_IDX_TRIG, 8'h01);
      evs("now", 1);
      chk("mask", last_ar, d[3:0]);
      chk("path", last_fast, 1'b0);
      wr(`NCOSC_IDX_TRIG, 8'h01);
      evs("rewrite", 0);
      wr(`NCOSC_IDX_TRIG, 8'h00);
      wr(`NCOSC_IDX_SYNC, {6'h00, `NCOSC_SRC_ONCE});
      wr(`NCOSC_IDX_TRIG, 8'h01);
      evs("armed", 0);
      far.pulse_sysref;
      evs("once", 1);
      far.pulse_sysref;
      evs("spent", 0);
      wr(`NCOSC_IDX_TRIG, 8'h00);
      wr(`NCOSC_IDX_SYNC, {6'h00, `NCOSC_SRC_EVERY});
      wr(`NCOSC_IDX_TRIG, 8'h01);
      repeat (2) far.pulse_sysref;
      evs("every", 2);
      // Frozen clock enable must swallow a whole pulse
      aclken <= 1'b0;
      far.pulse_sysref;
      aclken <= 1'b1;
      evs("frozen", 0);
      wr(`NCOSC_IDX_TRIG, 8'h00);
      far.pulse_sysref;
      evs("stopped", 0);
      wr(`NCOSC_IDX_SYNC, {6'h00, `NCOSC_SRC_LSB});
      wr(`NCOSC_IDX_TRIG, 8'h01);
      far.lsb_run(4, 3);
      evs("short high", 0);
      far.lsb_run(3, 4);
      evs("short low", 0);
      far.lsb_run(4, 8);
      evs("pattern", 1);
      wr(`NCOSC_IDX_TRIG, 8'h00);
      wr(`NCOSC_IDX_CTRL, 8'h02);
      datapath_enable <= 1'b1;
      cyc(2);
      chk("synth", synth_config, 1'b1);
      @(posedge aclk);
      datapath_enable <= 1'b0;
      wr(`NCOSC_IDX_SYNC, {6'h00, `NCOSC_SRC_NOW});
      wr(`NCOSC_IDX_CTRL, 8'h80);
      d = 8'($urandom);
      far.pulse_cs(1'b1, d[3:0]);
      evs("cs", 1);
      chk("fast mask", last_ar, d[3:0]);
      chk("fast path", last_fast, 1'b1);
      far.pulse_cs(1'b0, d[3:0]);
      evs("cs unselected", 0);
      wr(`NCOSC_IDX_SYNC, {6'h00, `NCOSC_SRC_LSB});
      z = n_zero;
      far.pulse_cs(1'b1, d[3:0]);
      chk("zeroed", n_zero > z, 1'b1);
      far.lsb_run(4, 5);
      evs("fast pattern", 1);
      z = n_zero;
      cyc(8);
      chk("data again", n_zero - z, 0);
      end_sim;
   end

   // The run needs under a thousand cycles; this bound is far beyond it
   initial begin
      #2000000;
      n_errors++;
      end_sim;
   end
endmodule
